/* File: hw/ssh_device.sv */
// ssh_device: start-up status capture plus host port device end.
// assumes straps are stable while presetn is low; apb slave on pclk.
//
// Functional notes
// - boot and enable latched at reset release
// - boot field 00/01/10 per mode
// - code 11 treated as no-boot mode
// - switch on gives enable bit zero
// - switch off gives enable bit one
// - no switch variant: enable always one
// - disabled port: data lines become gpio
// - chip select tied 0, strobe tied 1
// - host address lines drive select inputs
// - eight-bit tri-state data bus shared
// - host strobes low, direction by write-enable
// - device ready output is active low
// - interrupt to host is active low
// - host may reset board low
// - enabled port: interrupts both directions
// - enhanced variant: eight-bit mode only
// - disabled port: host irq pin as timer
`timescale 1ns/1ps
module ssh_device
    import ssh_pkg::*;
#(
    parameter bit HAS_SWITCH = 1'b1,
    parameter bit TIMER_VAR  = 1'b1
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // straps and board
    input  wire logic [1:0]  boot_strap,
    input  wire logic        host_port_disable_switch,
    input  wire logic        timer_one_in,
    output logic             expansion_timer_pin,
    output logic             irq,
    // host port connector
    ssh_link_if.device       link
);
    import ssh_pkg::*;

    // ------------------------------------------------------------------
    // reset release capture
    // ------------------------------------------------------------------
    logic                  captured;
    logic [1:0]            boot_sel;
    logic                  host_port_on;
    logic [SSH_STAT_W-1:0] startup_status;
    logic                  rst_n_all;

    // host reset pulls the start-up capture into reset too; kept simple, no filter
    assign rst_n_all = presetn & link.board_reset_n;

    always_ff @(posedge pclk or negedge rst_n_all) begin
        if (!rst_n_all) begin
            captured     <= 1'b0;
            boot_sel     <= SSH_PROCESSOR_NO_BOOT;
            host_port_on <= 1'b0;
        end else if (!captured) begin
            captured     <= 1'b1;
            // reserved code reads as is but acts as no-boot
            boot_sel     <= boot_strap;
            host_port_on <= HAS_SWITCH ? ~host_port_disable_switch
                                       : 1'b1;
        end
    end

    logic boot_from_host;
    assign boot_from_host = (boot_sel == SSH_CONTROLLER_HOST_BOOT);

    always_comb begin
        startup_status                  = SSH_STAT_RESET;
        startup_status[SSH_BOOT_LO_BIT] = boot_sel[0];
        startup_status[SSH_BOOT_HI_BIT] = boot_sel[1];
        startup_status[SSH_HOST_ON_BIT] = host_port_on;
    end

    // ------------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------------
    logic [SSH_IRQ_W-1:0]  irq_stat;
    logic [SSH_IRQ_W-1:0]  irq_mask;
    logic [SSH_CTRL_W-1:0] ctrl;
    logic [7:0]            gpio_out;
    logic [7:0]            gpio_oe;
    logic [7:0]            host_rd;
    logic [7:0]            host_wr;
    logic                  wr_en;
    logic                  rd_en;
    logic [SSH_IRQ_W-1:0]  ev;

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= '0;
            irq_mask <= '0;
            gpio_out <= 8'h00;
            gpio_oe  <= 8'h00;
            host_rd  <= 8'h00;
        end else if (wr_en) begin
            unique case (paddr)
                SSH_ADDR_CTRL:     ctrl     <= pwdata[SSH_CTRL_W-1:0];
                SSH_ADDR_IRQ_MASK: irq_mask <= pwdata[SSH_IRQ_W-1:0];
                SSH_ADDR_GPIO_OUT: gpio_out <= pwdata[7:0];
                SSH_ADDR_GPIO_OE:  gpio_oe  <= pwdata[7:0];
                SSH_ADDR_HOST_RD:  host_rd  <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // sticky events; set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~((wr_en && paddr == SSH_ADDR_IRQ_STAT)
                                      ? pwdata[SSH_IRQ_W-1:0] : '0)) | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // zero-wait-state read: data set in setup, pready in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (rd_en) begin
                unique case (paddr)
                    SSH_ADDR_STATUS:   prdata <= 32'(startup_status);
                    SSH_ADDR_IRQ_STAT: prdata <= 32'(irq_stat);
                    SSH_ADDR_IRQ_MASK: prdata <= 32'(irq_mask);
                    SSH_ADDR_CTRL:     prdata <= 32'(ctrl);
                    SSH_ADDR_GPIO_OUT: prdata <= 32'(gpio_out);
                    SSH_ADDR_GPIO_OE:  prdata <= 32'(gpio_oe);
                    SSH_ADDR_GPIO_IN:  prdata <= 32'(link.host_data_lines);
                    SSH_ADDR_HOST_RD:  prdata <= 32'(host_rd);
                    SSH_ADDR_HOST_WR:  prdata <= 32'(host_wr);
                    default:           prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // host port device end
    // ------------------------------------------------------------------
    logic strobe_d;
    logic strobe_fall;
    assign strobe_fall = strobe_d & ~link.host_data_strobe_n;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_d <= 1'b1;
        end else begin
            strobe_d <= link.host_data_strobe_n;
        end
    end

    // only the 8-bit enhanced mode exists here: one byte per strobe
    always_comb begin
        ev = '0;
        if (host_port_on && strobe_fall) begin
            ev[SSH_IRQ_WR_BIT]   = ~link.host_write_en_n &
                                   (link.reg_sel != SSH_SEL_BELL);
            ev[SSH_IRQ_RD_BIT]   = link.host_write_en_n;
            ev[SSH_IRQ_BELL_BIT] = ~link.host_write_en_n &
                                   (link.reg_sel == SSH_SEL_BELL);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_wr <= 8'h00;
        end else if (ev[SSH_IRQ_WR_BIT]) begin
            host_wr <= link.host_data_lines;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.host_chip_sel    <= 1'b0;
            link.addr_strobe      <= 1'b1;
            link.host_ready_out_n <= 1'b1;
            link.irq_to_host_n    <= 1'b1;
            link.dev_data_o       <= 8'h00;
            link.dev_data_oe      <= 1'b0;
            expansion_timer_pin   <= 1'b0;
        end else begin
            link.host_chip_sel <= 1'b0;
            link.addr_strobe   <= 1'b1;
            // ready one cycle after strobe seen, held while strobe low
            link.host_ready_out_n <= ~(host_port_on &
                                      ~link.host_data_strobe_n);
            if (host_port_on) begin
                link.dev_data_o  <= host_rd;
                link.dev_data_oe <= ~link.host_data_strobe_n &
                                    link.host_write_en_n;
                link.irq_to_host_n <= ~ctrl[SSH_CTRL_IRQ_HOST];
            end else begin
                link.dev_data_o  <= gpio_out;
                link.dev_data_oe <= |gpio_oe;
                link.irq_to_host_n <= (TIMER_VAR &&
                                       ctrl[SSH_CTRL_TIMER_PIN])
                                      ? timer_one_in
                                      : 1'b1;
            end
            expansion_timer_pin <= TIMER_VAR & ~host_port_on &
                                   ctrl[SSH_CTRL_TIMER_ROUT] &
                                   timer_one_in;
        end
    end

    logic unused_boot;
    assign unused_boot = boot_from_host;

endmodule // ssh_device

/* File: hw/ssh_host.sv */
// ssh_host: host controller end of the host port.
// assumes orders arrive on a simple strobe/ack user port on pclk.
`timescale 1ns/1ps
module ssh_host
    import ssh_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // user order port
    input  wire logic        req,
    input  wire logic        req_write,
    input  wire logic [2:0]  req_addr,
    input  wire logic [7:0]  req_wdata,
    input  wire logic        req_board_reset,
    output logic             done,
    output logic      [7:0]  rdata,
    output logic             dev_irq,
    // host port connector
    ssh_link_if.host         link
);
    import ssh_pkg::*;

    // ------------------------------------------------------------------
    // transfer engine
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SSH_H_IDLE = 3'b001,
        SSH_H_WAIT = 3'b010,
        SSH_H_END  = 3'b100
    } ssh_hst_t;

    ssh_hst_t state;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                   <= SSH_H_IDLE;
            link.reg_sel            <= 3'h0;
            link.host_data_strobe_n <= 1'b1;
            link.host_write_en_n    <= 1'b1;
            link.host_data_o        <= 8'h00;
            link.host_data_oe       <= 1'b0;
            done                    <= 1'b0;
            rdata                   <= 8'h00;
        end else begin
            done <= 1'b0;
            unique case (state)
                SSH_H_IDLE: if (req) begin
                    link.reg_sel            <= req_addr;
                    link.host_write_en_n    <= ~req_write;
                    link.host_data_o        <= req_wdata;
                    link.host_data_oe       <= req_write;
                    link.host_data_strobe_n <= 1'b0;
                    state                   <= SSH_H_WAIT;
                end
                SSH_H_WAIT: if (!link.host_ready_out_n) begin
                    rdata                   <= link.host_data_lines;
                    link.host_data_strobe_n <= 1'b1;
                    link.host_data_oe       <= 1'b0;
                    state                   <= SSH_H_END;
                end
                SSH_H_END: begin
                    link.host_write_en_n <= 1'b1;
                    done                 <= 1'b1;
                    state                <= SSH_H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.board_reset_n <= 1'b1;
            dev_irq            <= 1'b0;
        end else begin
            link.board_reset_n <= ~req_board_reset;
            dev_irq            <= ~link.irq_to_host_n;
        end
    end

endmodule // ssh_host

/* File: hw/ssh_link_if.sv */
// ssh_link_if: host port connector between device end and host end.
// assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface ssh_link_if;
    logic       host_chip_sel;
    logic       addr_strobe;
    logic [2:0] reg_sel;
    logic       host_data_strobe_n;
    logic       host_write_en_n;
    logic       host_ready_out_n;
    logic       irq_to_host_n;
    logic       board_reset_n;
    logic [7:0] dev_data_o;
    logic       dev_data_oe;
    logic [7:0] host_data_o;
    logic       host_data_oe;
    logic [7:0] host_data_lines;

    // wire level of the shared data bus; pulled high when nobody drives
    assign host_data_lines = dev_data_oe  ? dev_data_o  :
                             host_data_oe ? host_data_o : 8'hFF;

    modport device (
        input  reg_sel, host_data_strobe_n, host_write_en_n,
        input  board_reset_n, host_data_lines,
        output host_chip_sel, addr_strobe, host_ready_out_n,
        output irq_to_host_n, dev_data_o, dev_data_oe
    );
    modport host (
        input  host_chip_sel, addr_strobe, host_ready_out_n,
        input  irq_to_host_n, host_data_lines,
        output reg_sel, host_data_strobe_n, host_write_en_n,
        output board_reset_n, host_data_o, host_data_oe
    );
endinterface

/* File: hw/ssh_pkg.sv */
// ssh_pkg: constants shared by the host-port device end and the host end.
// assumes one 100 MHz clock (pclk) and an active-low async reset.
package ssh_pkg;

    // ------------------------------------------------------------------
    // boot mode codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SSH_PROCESSOR_NO_BOOT     = 2'h0,
        SSH_CONTROLLER_FLASH_BOOT = 2'h1,
        SSH_CONTROLLER_HOST_BOOT  = 2'h2,
        SSH_BOOT_RESERVED         = 2'h3
    } ssh_boot_t;

    // ------------------------------------------------------------------
    // startup_status layout (16 bits)
    // ------------------------------------------------------------------
    localparam int          SSH_STAT_W      = 16;
    localparam int          SSH_BOOT_LO_BIT = 0;
    localparam int          SSH_BOOT_HI_BIT = 1;
    localparam int          SSH_HOST_ON_BIT = 3;
    localparam logic [15:0] SSH_STAT_RESET  = 16'h0000;

    // ------------------------------------------------------------------
    // host port register select codes (a2..a0 = ctrl1, ctrl0, byte)
    // ------------------------------------------------------------------
    localparam int SSH_DATA_W = 8;
    localparam int SSH_SEL_W  = 3;

    // ------------------------------------------------------------------
    // apb map of the device end (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] SSH_ADDR_STATUS   = 12'h000;
    localparam logic [11:0] SSH_ADDR_IRQ_STAT = 12'h004;
    localparam logic [11:0] SSH_ADDR_IRQ_MASK = 12'h008;
    localparam logic [11:0] SSH_ADDR_CTRL     = 12'h00C;
    localparam logic [11:0] SSH_ADDR_GPIO_OUT = 12'h010;
    localparam logic [11:0] SSH_ADDR_GPIO_OE  = 12'h014;
    localparam logic [11:0] SSH_ADDR_GPIO_IN  = 12'h018;
    localparam logic [11:0] SSH_ADDR_HOST_RD  = 12'h01C;
    localparam logic [11:0] SSH_ADDR_HOST_WR  = 12'h020;

    // ctrl bits
    localparam int SSH_CTRL_IRQ_HOST   = 0;
    localparam int SSH_CTRL_TIMER_PIN  = 1;
    localparam int SSH_CTRL_TIMER_ROUT = 2;
    localparam int SSH_CTRL_W          = 3;

    // irq status bits: 0 host write, 1 host read, 2 host doorbell
    localparam int SSH_IRQ_W        = 3;
    localparam int SSH_IRQ_WR_BIT   = 0;
    localparam int SSH_IRQ_RD_BIT   = 1;
    localparam int SSH_IRQ_BELL_BIT = 2;

    // host-side doorbell select code
    localparam logic [2:0] SSH_SEL_BELL = 3'h7;

endpackage

/* File: tb/ssh_link_properties.sv */
// ssh_link_properties: concurrent checks on the host port connector.
// assumes it is instantiated beside the link interface, pclk domain only.
`timescale 1ns/1ps
module ssh_link_properties (
    // clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // link signals
    input wire logic       host_chip_sel,
    input wire logic       addr_strobe,
    input wire logic [2:0] reg_sel,
    input wire logic       host_data_strobe_n,
    input wire logic       host_write_en_n,
    input wire logic       host_ready_out_n,
    input wire logic       dev_data_oe,
    input wire logic       host_data_oe
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_cs; host_chip_sel == 1'b0; endproperty
    a_cs: assert property (p_cs)
        else $error("chip select left active level");
    property p_as; addr_strobe == 1'b1; endproperty
    a_as: assert property (p_as)
        else $error("address strobe not held high");
    // ready answers exactly one cycle after the strobe fell
    property p_rdy_fall;
        $fell(host_ready_out_n) |-> !host_data_strobe_n &&
            !$past(host_data_strobe_n) && $past(host_data_strobe_n, 2);
    endproperty
    a_rdy_fall: assert property (p_rdy_fall)
        else $error("ready fell with wrong latency");
    property p_rdy_rise;
        $rose(host_ready_out_n) |-> host_data_strobe_n &&
            $past(host_data_strobe_n);
    endproperty
    a_rdy_rise: assert property (p_rdy_rise)
        else $error("ready released while strobe low");
    property p_no_fight; !(dev_data_oe && host_data_oe); endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("both ends drive the data bus");
    property p_host_dir; host_data_oe |-> !host_write_en_n; endproperty
    a_host_dir: assert property (p_host_dir)
        else $error("host drives data on a read");
    property p_sel_stable;
        !host_data_strobe_n && !$past(host_data_strobe_n) |->
            $stable(reg_sel) && $stable(host_write_en_n);
    endproperty
    a_sel_stable: assert property (p_sel_stable)
        else $error("select or direction moved under strobe");
    property p_rd_drive;
        !host_ready_out_n && host_write_en_n |-> dev_data_oe;
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("device not driving read data when ready");
    property p_release;
        $fell(host_ready_out_n) |-> ##[1:2] host_data_strobe_n;
    endproperty
    a_release: assert property (p_release)
        else $error("host kept strobe low after ready");
endmodule // ssh_link_properties

/* File: tb/tb.sv */
// tb: self-checking bench joining device end and host end over the link.
// assumes the ssh_pkg register map and a 100 MHz pclk.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    num_errors++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
    end end
module tb;
    import ssh_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0]  boot_strap;
    logic        sw, timer_one_in, expansion_timer_pin, irq, slv_err;
    logic        req, req_write, req_board_reset, done, dev_irq;
    logic [2:0]  req_addr, a;
    logic [7:0]  req_wdata, rdata;
    logic [15:0] lfsr = 16'h004D;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    // ------------------------------------------------------------------
    // design and checker
    // ------------------------------------------------------------------
    ssh_link_if ssh_link_if_inst ();
    ssh_device #(.HAS_SWITCH(1'b1), .TIMER_VAR(1'b1)) ssh_device_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .boot_strap(boot_strap),
        .host_port_disable_switch(sw), .timer_one_in(timer_one_in),
        .expansion_timer_pin(expansion_timer_pin), .irq(irq),
        .link(ssh_link_if_inst.device));
    ssh_host ssh_host_inst (
        .pclk(pclk), .presetn(presetn), .req(req), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata),
        .req_board_reset(req_board_reset), .done(done), .rdata(rdata),
        .dev_irq(dev_irq), .link(ssh_link_if_inst.host));
    ssh_link_properties ssh_link_properties_inst (
        .pclk(pclk), .presetn(presetn),
        .host_chip_sel(ssh_link_if_inst.host_chip_sel),
        .addr_strobe(ssh_link_if_inst.addr_strobe),
        .reg_sel(ssh_link_if_inst.reg_sel),
        .host_data_strobe_n(ssh_link_if_inst.host_data_strobe_n),
        .host_write_en_n(ssh_link_if_inst.host_write_en_n),
        .host_ready_out_n(ssh_link_if_inst.host_ready_out_n),
        .dev_data_oe(ssh_link_if_inst.dev_data_oe),
        .host_data_oe(ssh_link_if_inst.host_data_oe));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [15:0] step(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // enable bit reads one only with the disable switch off
    function automatic logic [31:0] exp_stat(logic [1:0] b, logic s);
        return {28'h0000000, ~s, 1'b0, b};
    endfunction

    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    // request held until pready is sampled high, no fixed wait assumed
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        slv_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic hx(input logic w, input logic [2:0] ad,
                      input logic [7:0] d);
        @(posedge pclk);
        req       <= 1'b1;
        req_write <= w;
        req_addr  <= ad;
        req_wdata <= d;
        @(posedge pclk);
        req <= 1'b0;
        do @(posedge pclk); while (done !== 1'b1);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        boot_strap = 2'h0;
        sw = 1'b0;
        timer_one_in = 1'b0;
        req = 1'b0;
        req_write = 1'b0;
        req_addr = 3'h0;
        req_wdata = 8'h00;
        req_board_reset = 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            boot_strap <= i[1:0];
            sw         <= i[2];
            do_reset();
            boot_strap <= ~i[1:0];
            sw         <= ~i[2];
            apb(1'b1, SSH_ADDR_STATUS, 32'hFFFFFFFF);
            apb(1'b0, SSH_ADDR_STATUS, 32'h00000000);
            `CHK(q, exp_stat(i[1:0], i[2]))
        end
        boot_strap <= 2'h2;
        sw <= 1'b0;
        req_board_reset <= 1'b1;
        repeat (3) @(posedge pclk);
        req_board_reset <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b0, SSH_ADDR_STATUS, 32'h00000000);
        `CHK(q, exp_stat(2'h2, 1'b0))
        $display("test strap capture done");
        apb(1'b1, SSH_ADDR_IRQ_STAT, 32'h00000007);
        apb(1'b1, SSH_ADDR_IRQ_MASK, 32'h00000000);
        for (int k = 0; k < 8; k++) begin
            lfsr = step(lfsr);
            a = (lfsr[2:0] == SSH_SEL_BELL) ? 3'h0 : lfsr[2:0];
            hx(1'b1, a, lfsr[15:8]);
            apb(1'b0, SSH_ADDR_HOST_WR, 32'h00000000);
            `CHK(q[7:0], lfsr[15:8])
            apb(1'b1, SSH_ADDR_HOST_RD, {24'h000000, lfsr[7:0]});
            hx(1'b0, a, 8'h00);
            apb(1'b0, SSH_ADDR_IRQ_STAT, 32'h00000000);
            `CHK(rdata, lfsr[7:0])
            `CHK(q[1:0], 2'h3)
            apb(1'b1, SSH_ADDR_IRQ_STAT, 32'h00000003);
            apb(1'b0, SSH_ADDR_IRQ_STAT, 32'h00000000);
            `CHK(q[1:0], 2'h0)
        end
        $display("test host traffic done");
        hx(1'b1, SSH_SEL_BELL, 8'hA5);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b0, SSH_ADDR_IRQ_STAT, 32'h00000000);
        `CHK(q[SSH_IRQ_BELL_BIT], 1'b1)
        apb(1'b1, SSH_ADDR_IRQ_MASK, 32'h00000004);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b1, SSH_ADDR_IRQ_STAT, 32'h00000004);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        for (int v = 1; v >= 0; v--) begin
            apb(1'b1, SSH_ADDR_CTRL, v);
            repeat (3) @(posedge pclk);
            `CHK(dev_irq, v[0])
            `CHK(ssh_link_if_inst.irq_to_host_n, ~v[0])
        end
        apb(1'b1, 12'h0FC, 32'hFFFFFFFF);
        apb(1'b0, 12'h0FC, 32'h00000000);
        `CHK(q, 32'h00000000)
        `CHK(slv_err, 1'b0)
        $display("test interrupts done");
        boot_strap <= 2'h0;
        sw <= 1'b1;
        do_reset();
        lfsr = step(lfsr);
        apb(1'b1, SSH_ADDR_GPIO_OE, 32'h00000001);
        apb(1'b1, SSH_ADDR_GPIO_OUT, {24'h000000, lfsr[7:0]});
        repeat (2) @(posedge pclk);
        `CHK(ssh_link_if_inst.host_data_lines, lfsr[7:0])
        apb(1'b0, SSH_ADDR_GPIO_IN, 32'h00000000);
        `CHK(q[7:0], lfsr[7:0])
        apb(1'b1, SSH_ADDR_GPIO_OE, 32'h00000000);
        apb(1'b0, SSH_ADDR_GPIO_IN, 32'h00000000);
        `CHK(q[7:0], 8'hFF)
        apb(1'b1, SSH_ADDR_CTRL, 32'h00000006);
        for (int t = 1; t >= 0; t--) begin
            timer_one_in <= t[0];
            repeat (3) @(posedge pclk);
            `CHK(expansion_timer_pin, t[0])
            `CHK(ssh_link_if_inst.irq_to_host_n, t[0])
        end
        $display("test disabled port done");
        give_verdict();
    end
endmodule // tb
